// File: hdl/adc_group_buffer_sequencer.sv
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/100ps
//
// Function
// - group-single: start flag held, then auto-cleared
// - group-single: end flag set, interrupt if enabled
// - end flag clears by zero-write after read
// - group-scan: start held, conversions repeat
// - group-scan: end flag pauses with irq, resumes
// - new result shifts older into next register
// - three chains: A-B, A-C/B-D, A-B-C-D
// - buffer-only: channel code sets conversion count
// - single stops at end flag; scan continues
// - select-single: buffer setting ignored, one conversion per start
// - channel code appends inputs 2-7 (A-B) or 4-7 (A-C/B-D, A-B-C-D) after buffer
// - transfer-service read of last result in group mode, or of A in select mode, clears end flag
// - buffer field zero resets buffer count
// - new buffer scheme applies on next start
// - simultaneous sampling in group mode only
// - upper channel bits choose pair count
// - low-power: power up, first after 200 cycles
// - low-power: later conversions take 10 cycles
// - low-power: end clears start, cuts power
// - high-speed: stays powered, warm-up once 200
// - high-speed: 20 cycles each; bit clear powers down
// - buffer field codes 00,01,10,11
// - start mode resets to low-power
// - trigger sets start flag like software
module adc_group_buffer_sequencer
    import adc_seq_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timer_trigger_unit,
    input  wire logic        external_trigger_pin,
    input  wire logic        xfer_service,
    output logic             conversion_end_irq,
    output logic             analog_power,
    output logic             sample_strobe,
    output logic [2:0]       sample_channel,
    input  wire logic [9:0]  conv_data,
    output logic [1:0]       conv_clock_select
);

    ctrl_stat_t  cs_r;
    config_t     cf_r;
    seq_state_t  state_r;
    logic [9:0]  res_r [8];
    logic [7:0]  tmr_r;
    logic [2:0]  step_r;
    logic [1:0]  bufcnt_r;
    logic        powered_r;
    logic        cs_read_r;
    logic        ext_m_r, ext_s_r, ext_d_r;
    logic        trg_m_r, trg_s_r, trg_d_r;
    logic [31:0] prdata_r;
    logic        irq_r, strb_r;
    logic [2:0]  chan_r;

    //////////////////////////////////////////////////////////////////////////
    // bus decode
    wire        wr_acc   = psel & penable & pwrite & clk_en;
    wire        rd_acc   = psel & penable & ~pwrite & clk_en;
    wire        hit_res  = (paddr <= OFS_RESULT_H) && (paddr[1:0] == 2'b00);
    wire [2:0]  res_idx  = paddr[4:2];
    wire        hit_cs   = paddr == OFS_CTRL_STAT;
    wire        hit_cf   = (paddr == OFS_CONFIG) || (paddr == OFS_CONFIG_ALT);
    wire        hit_st   = paddr == OFS_STATUS;
    wire        mapped   = hit_res | hit_cs | hit_cf | hit_st;
    wire        halted   = ~cs_r.start;

    //////////////////////////////////////////////////////////////////////////
    // sequence plan: channel of each step, result slot, index of the last step
    wire        bufmode  = cs_r.group & (cf_r.buf_sel != BUF_NONE);
    wire        simul_on = cs_r.group & cf_r.simul;

    // index of the last step of one pass
    function automatic logic [2:0] pass_len(input logic group_mode_select, input logic sim, input logic [1:0] bsel,
                                            input logic [2:0] ch);
        logic [2:0] n;
        n = 3'd0;
        if (!group_mode_select)
            n = 3'd0;
        else if (sim)
            n = 3'({ch[2:1], 1'b1});
        else if (bsel == BUF_NONE)
            n = ch;
        else if (!ch[2] && !(bsel == BUF_AB && ch[1]))
            n = (bsel == BUF_ACBD) ? 3'({2'b00, ch[1]}) : 3'd0;
        else if (bsel == BUF_AB)
            n = 3'(ch - 3'd1);
        else if (bsel == BUF_ACBD)
            n = 3'(ch - 3'd2);
        else
            n = 3'(ch - 3'd3);
        return n;
    endfunction : pass_len

    // input channel used at a step
    function automatic logic [2:0] step_chan(input logic group_mode_select, input logic sim, input logic [1:0] bsel,
                                             input logic [2:0] ch, input logic [2:0] st);
        logic [2:0] c;
        c = st;
        if (!group_mode_select)
            c = ch;
        else if (sim || bsel == BUF_NONE)
            c = st;
        else if (!ch[2] && !(bsel == BUF_AB && ch[1]))
            c = (bsel == BUF_ACBD) ? 3'({2'b00, st[0]}) : 3'd0;
        else if (st == 3'd0)
            c = 3'd0;
        else if (bsel == BUF_AB)
            c = 3'(st + 3'd1);
        else if (bsel == BUF_ACBD)
            c = (st == 3'd1) ? 3'd1 : 3'(st + 3'd2);
        else
            c = 3'(st + 3'd3);
        return c;
    endfunction : step_chan

    wire [2:0]  last_step = pass_len(cs_r.group, simul_on, cf_r.buf_sel, cs_r.ch);
    wire [2:0]  cur_chan  = step_chan(cs_r.group, simul_on, cf_r.buf_sel, cs_r.ch, step_r);
    // buffer-only repeats in a two-/four-stage chain count passes of input 0 (inputs 0 and 1 for A-C/B-D)
    wire        buf_only  = bufmode & ~cs_r.ch[2] & ~(cf_r.buf_sel == BUF_AB & cs_r.ch[1]);
    wire [1:0]  buf_need  = (cf_r.buf_sel == BUF_ACBD) ? 2'({1'b0, cs_r.ch[1]}) : cs_r.ch[1:0];
    wire        chain_ch  = bufmode & (cur_chan == 3'd0 | (cf_r.buf_sel == BUF_ACBD & cur_chan == 3'd1));
    wire        last_conv = buf_only ? (step_r == (cf_r.buf_sel == BUF_ACBD ? 3'd1 : 3'd0))
                                     : (step_r == last_step);
    wire        pass_end  = last_conv & (~buf_only | bufcnt_r == buf_need);
    wire        scan_on   = cf_r.scan;

    // result register whose read closes the transfer service
    wire [2:0]  final_slot = buf_only ? (cf_r.buf_sel == BUF_ACBD ? (cs_r.ch[1] ? 3'd3 : 3'd1)
                                                                 : 3'({1'b0, cs_r.ch[1:0]}))
                                      : (simul_on | ~bufmode ? last_step : cs_r.ch);
    wire [2:0]  slot_of    = (bufmode & cur_chan == 3'd0) ? 3'd0 :
                             (bufmode & cf_r.buf_sel == BUF_ACBD & cur_chan == 3'd1) ? 3'd1 : cur_chan;

    wire        trig_evt  = (cf_r.trig == TRIG_TIMER & trg_s_r & ~trg_d_r) |
                            (cf_r.trig == TRIG_EXT & ext_s_r & ~ext_d_r);
    wire        sw_start  = wr_acc & hit_cs & pwdata[CS_START] & halted;
    wire        go        = halted & (sw_start | trig_evt);
    wire        conv_done = state_r == ST_CONV && tmr_r == 8'h00;
    wire        set_end   = conv_done & pass_end;
    wire [7:0]  conv_cnt  = cf_r.start_mode ? FAST_CONV_CNT : LOWPWR_CONV_CNT;
    wire        clr_try   = wr_acc & hit_cs & ~pwdata[CS_END_FLAG] & cs_read_r;
    wire        xfer_clr  = rd_acc & hit_res & xfer_service & res_idx == final_slot;
    wire        end_clr   = (clr_try | xfer_clr) & ~set_end;
    wire        stop_sw   = wr_acc & hit_cs & ~pwdata[CS_START];
    wire        pause_req = scan_on & cs_r.irq_en;
    wire        buf_zero  = wr_acc & hit_cf & pwdata[1:0] == BUF_NONE & halted;

    //////////////////////////////////////////////////////////////////////////
    // control and configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cs_r      <= CS_RESET;
            cf_r      <= CF_RESET;
            cs_read_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_acc & hit_cs & halted)
            begin
                cs_r.ch     <= pwdata[CS_CH_LSB +: 3];
                cs_r.group  <= pwdata[CS_GROUP];
                cs_r.clksel <= pwdata[CS_CLKSEL +: 2];
                cs_r.irq_en <= pwdata[CS_IRQ_EN];
            end
            else if (wr_acc & hit_cs)
                cs_r.irq_en <= pwdata[CS_IRQ_EN];
            if (wr_acc & hit_cf & halted)
                cf_r <= pwdata[6:0];
            if (set_end)
                cs_r.end_flag <= 1'b1;
            else if (end_clr)
                cs_r.end_flag <= 1'b0;
            if (rd_acc & hit_cs)
                cs_read_r <= cs_r.end_flag;
            else if (clr_try)
                cs_read_r <= 1'b0;
            if (go)
                cs_r.start <= 1'b1;
            else if (stop_sw | (set_end & ~scan_on))
                cs_r.start <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r   <= ST_IDLE;
            tmr_r     <= 8'h00;
            step_r    <= 3'd0;
            bufcnt_r  <= 2'd0;
            powered_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (buf_zero)
                bufcnt_r <= 2'd0;
            if (wr_acc & hit_cf & halted & ~pwdata[CF_STARTMD])
                powered_r <= 1'b0;
            unique case (state_r)
                ST_IDLE:
                    if (go)
                    begin
                        step_r <= 3'd0;
                        if (powered_r)
                        begin
                            state_r <= ST_CONV;
                            tmr_r   <= conv_cnt;
                        end
                        else
                        begin
                            state_r <= ST_WARMUP;
                            tmr_r   <= WARMUP_CNT;
                        end
                    end
                ST_WARMUP:
                    if (stop_sw)
                        state_r <= ST_IDLE;
                    else if (tmr_r == 8'h00)
                    begin
                        powered_r <= 1'b1;
                        state_r   <= ST_CONV;
                        tmr_r     <= conv_cnt;
                    end
                    else
                        tmr_r <= 8'(tmr_r - 8'd1);
                ST_CONV:
                    if (stop_sw)
                        state_r <= ST_IDLE;
                    else if (tmr_r != 8'h00)
                        tmr_r <= 8'(tmr_r - 8'd1);
                    else
                    begin
                        tmr_r  <= conv_cnt;
                        step_r <= last_conv ? 3'd0 : 3'(step_r + 3'd1);
                        if (buf_only & last_conv)
                            bufcnt_r <= pass_end ? 2'd0 : 2'(bufcnt_r + 2'd1);
                        if (set_end & ~scan_on)
                            state_r <= ST_IDLE;
                        else if (set_end & pause_req)
                            state_r <= ST_PAUSE;
                        else if (buf_only & last_conv & ~scan_on & ~cs_r.group)
                            state_r <= ST_IDLE;
                        else
                            state_r <= ST_CONV;
                    end
                ST_PAUSE:
                    if (stop_sw)
                        state_r <= ST_IDLE;
                    else if (~cs_r.end_flag)
                        state_r <= ST_CONV;
                default:
                    state_r <= ST_IDLE;
            endcase
            if (state_r == ST_IDLE && !cf_r.start_mode && !go)
                powered_r <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // result chain: shift on each conversion of a buffered input
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_res
            wire shift_in = conv_done & chain_ch & (
                (gi == 1 & cf_r.buf_sel == BUF_AB) |
                (gi == 1 & cf_r.buf_sel == BUF_ABCD) |
                (gi == 2 & cf_r.buf_sel == BUF_ABCD) |
                (gi == 3 & cf_r.buf_sel == BUF_ABCD) |
                (gi >= 2 & gi <= 3 & cf_r.buf_sel == BUF_ACBD & slot_of == 3'(gi - 2)));
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    res_r[gi] <= RES_RESET;
                else if (clk_en)
                begin
                    if (shift_in)
                        res_r[gi] <= res_r[(gi == 1) ? 0 : (gi == 2 & cf_r.buf_sel == BUF_ABCD) ? 1 :
                                           (gi == 3 & cf_r.buf_sel == BUF_ABCD) ? 2 : gi - 2];
                    else if (conv_done & slot_of == 3'(gi))
                        res_r[gi] <= conv_data;
                end
            end
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // pin sync, bus answer and outputs
    wire [31:0] rd_mux = hit_res ? {22'h000000, res_r[res_idx]} :
                         hit_cs  ? {23'h000000, cs_r} :
                         hit_cf  ? {25'h0000000, cf_r} :
                         hit_st  ? {26'h0000000, bufcnt_r, powered_r, step_r[0], state_r} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {ext_m_r, ext_s_r, ext_d_r} <= 3'b000;
            {trg_m_r, trg_s_r, trg_d_r} <= 3'b000;
            prdata_r <= 32'h00000000;
            irq_r    <= 1'b0;
            strb_r   <= 1'b0;
            chan_r   <= 3'd0;
        end
        else if (clk_en)
        begin
            {ext_m_r, ext_s_r, ext_d_r} <= {external_trigger_pin, ext_m_r, ext_s_r};
            {trg_m_r, trg_s_r, trg_d_r} <= {timer_trigger_unit, trg_m_r, trg_s_r};
            prdata_r <= rd_mux;
            irq_r    <= (cs_r.end_flag | set_end) & cs_r.irq_en & ~end_clr;
            strb_r   <= state_r == ST_CONV && tmr_r == conv_cnt;
            chan_r   <= cur_chan;
        end
    end

    // combinational read data keeps zero wait states; strobes registered
    assign prdata             = rd_acc ? rd_mux : prdata_r;
    assign pready             = 1'b1;
    assign pslverr            = psel & penable & ~mapped;
    assign conversion_end_irq = irq_r;
    assign analog_power       = powered_r | (state_r == ST_WARMUP);
    assign sample_strobe      = strb_r;
    assign sample_channel     = chan_r;
    assign conv_clock_select  = cs_r.clksel;

endmodule : adc_group_buffer_sequencer

// File: hdl/adc_seq_pkg.sv
package adc_seq_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_RESULT_A   = 8'h00;
    localparam logic [7:0] OFS_RESULT_H   = 8'h1C;
    localparam logic [7:0] OFS_CTRL_STAT  = 8'h20;
    localparam logic [7:0] OFS_CONFIG     = 8'h24;
    localparam logic [7:0] OFS_CONFIG_ALT = 8'h28;
    localparam logic [7:0] OFS_STATUS     = 8'h2C;

    // control/status fields
    localparam int CS_CH_LSB   = 0;
    localparam int CS_GROUP    = 3;
    localparam int CS_CLKSEL   = 4;
    localparam int CS_IRQ_EN   = 6;
    localparam int CS_END_FLAG = 7;
    localparam int CS_START    = 8;
    // configuration fields
    localparam int CF_BUF_LSB  = 0;
    localparam int CF_SIMUL    = 2;
    localparam int CF_SCAN     = 3;
    localparam int CF_TRIG_LSB = 4;
    localparam int CF_STARTMD  = 6;

    localparam logic [1:0] TRIG_SOFT  = 2'h0;
    localparam logic [1:0] TRIG_TIMER = 2'h1;
    localparam logic [1:0] TRIG_EXT   = 2'h3;

    localparam logic [1:0] BUF_NONE  = 2'h0;
    localparam logic [1:0] BUF_AB    = 2'h1;
    localparam logic [1:0] BUF_ACBD  = 2'h2;
    localparam logic [1:0] BUF_ABCD  = 2'h3;

    localparam logic [8:0]  CS_RESET  = 9'h000;
    localparam logic [6:0]  CF_RESET  = 7'h00;
    localparam logic [9:0]  RES_RESET = 10'h000;

    // timing in reference clock cycles
    localparam int WARMUP_CYC      = 200;
    localparam int LOWPWR_CONV_CYC = 10;
    localparam int FAST_CONV_CYC   = 20;
    localparam logic [7:0] WARMUP_CNT      = 8'(WARMUP_CYC - 1);
    localparam logic [7:0] LOWPWR_CONV_CNT = 8'(LOWPWR_CONV_CYC - 1);
    localparam logic [7:0] FAST_CONV_CNT   = 8'(FAST_CONV_CYC - 1);

    typedef struct packed {
        logic       start;
        logic       end_flag;
        logic       irq_en;
        logic [1:0] clksel;
        logic       group;
        logic [2:0] ch;
    } ctrl_stat_t;

    typedef struct packed {
        logic       start_mode;
        logic [1:0] trig;
        logic       scan;
        logic       simul;
        logic [1:0] buf_sel;
    } config_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_WARMUP = 2'b01,
        ST_CONV   = 2'b10,
        ST_PAUSE  = 2'b11
    } seq_state_t;

endpackage : adc_seq_pkg

// File: verif/analog_inputs.sv
`timescale 1ns/100ps
module analog_inputs
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       sample_strobe,
    input  wire logic [2:0] sample_channel,
    output logic      [9:0] conv_data
);
    // each sample carries its channel and a running count, so a shifted or misrouted result shows a wrong tag
    logic [6:0] cnt_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r     <= 7'h00;
            conv_data <= 10'h3FF;
        end
        else if (sample_strobe)
        begin
            cnt_r     <= cnt_r + 7'h01;
            conv_data <= {sample_channel, cnt_r};
        end
    end
endmodule : analog_inputs

// File: verif/adc_seq_monitor.sv
`timescale 1ns/100ps
module adc_seq_monitor
    import adc_seq_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        conversion_end_irq,
    input wire logic        analog_power,
    input wire logic        sample_strobe,
    input wire logic [1:0]  conv_clock_select
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // mode shadows assume software only reconfigures while stopped
    wire        wr     = psel && penable && pwrite && clk_en;
    wire        wr_cs  = wr && (paddr == OFS_CTRL_STAT);
    wire        wr_cf  = wr && (paddr == OFS_CONFIG || paddr == OFS_CONFIG_ALT);
    logic       sm_r;
    logic       ien_r;
    logic       first_r;
    logic [8:0] pw_cnt_r;
    logic [5:0] gap_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sm_r     <= 1'b0;
            ien_r    <= 1'b0;
            first_r  <= 1'b1;
            pw_cnt_r <= 9'h000;
            gap_r    <= 6'h00;
        end
        else
        begin
            if (wr_cf) sm_r <= pwdata[CF_STARTMD];
            if (wr_cs) ien_r <= pwdata[CS_IRQ_EN];
            first_r  <= !analog_power ? 1'b1 : (sample_strobe ? 1'b0 : first_r);
            pw_cnt_r <= !analog_power ? 9'h000 : (pw_cnt_r == 9'h1FF ? pw_cnt_r : pw_cnt_r + 9'h001);
            gap_r    <= sample_strobe ? 6'h00 : (gap_r == 6'h3F ? gap_r : gap_r + 6'h01);
        end
    end
    property p_warm; sample_strobe && first_r |-> pw_cnt_r >= 9'd198; endproperty
    a_warm: assert property (p_warm) else $error("first sample before warm-up");
    property p_gap; sample_strobe && !first_r |-> gap_r >= (sm_r ? 6'd19 : 6'd9); endproperty
    a_gap: assert property (p_gap) else $error("conversions too close");
    property p_nopwr; sample_strobe |-> analog_power; endproperty
    a_nopwr: assert property (p_nopwr) else $error("sample while unpowered");
    property p_hold; $fell(analog_power) |-> !sm_r; endproperty
    a_hold: assert property (p_hold) else $error("power dropped in fast mode");
    property p_irq; conversion_end_irq |-> ien_r || $past(ien_r); endproperty
    a_irq: assert property (p_irq) else $error("irq while disabled");
    property p_ready; psel |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err; psel && penable && (paddr > OFS_STATUS) |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("unmapped access accepted");
    property p_errq; pslverr |-> psel && penable; endproperty
    a_errq: assert property (p_errq) else $error("stray pslverr");
    property p_cks; !$stable(conv_clock_select) |-> $past(wr_cs); endproperty
    a_cks: assert property (p_cks) else $error("clock select changed alone");
    property p_rst; $rose(presetn) |-> !analog_power && !sample_strobe; endproperty
    a_rst: assert property (p_rst) else $error("active after reset");
    c_first: cover property (sample_strobe && first_r);
    c_irq: cover property ($rose(conversion_end_irq));
    c_err: cover property (pslverr);
endmodule : adc_seq_monitor

bind adc_group_buffer_sequencer adc_seq_monitor mon (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .conversion_end_irq(conversion_end_irq), .analog_power(analog_power), .sample_strobe(sample_strobe),
    .conv_clock_select(conv_clock_select));

// File: verif/testbench.sv
`timescale 1ns/100ps
module testbench;
    import adc_seq_pkg::*;
    logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic timer_trigger_unit = 0, external_trigger_pin = 0, xfer_service = 0;
    logic [7:0]  paddr  = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, conversion_end_irq, analog_power, sample_strobe;
    logic [2:0]  sample_channel;
    logic [9:0]  conv_data;
    logic [1:0]  conv_clock_select;
    logic [6:0]  n_strb = 7'h00, k;
    int          n_fail = 0, tests_run = 0;
    adc_group_buffer_sequencer uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_trigger_unit(timer_trigger_unit), .external_trigger_pin(external_trigger_pin),
        .xfer_service(xfer_service), .conversion_end_irq(conversion_end_irq), .analog_power(analog_power),
        .sample_strobe(sample_strobe), .sample_channel(sample_channel), .conv_data(conv_data),
        .conv_clock_select(conv_clock_select));
    analog_inputs far (.pclk(pclk), .presetn(presetn), .sample_strobe(sample_strobe),
        .sample_channel(sample_channel), .conv_data(conv_data));
    initial forever #12.5 pclk = ~pclk;
    always @(posedge pclk) if (sample_strobe === 1'b1) n_strb <= n_strb + 7'h01;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // request held until pready is seen high at an edge; read data taken at that same edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    task automatic wait_stop;
        int i;
        i = 0;
        do begin apb(0, OFS_CTRL_STAT, 0); i++; end while (rd[CS_START] !== 1'b0 && i < 600);
    endtask : wait_stop
    task automatic wait_irq;
        int i;
        for (i = 0; i < 3000 && conversion_end_irq !== 1'b1; i++) @(posedge pclk);
    endtask : wait_irq
    // software clears the flag with a read of it followed by a zero write; a transfer-service read also clears it
    task automatic clear_flag;
        apb(0, OFS_CTRL_STAT, 0);
        apb(1, OFS_CTRL_STAT, rd & ~32'h080);
    endtask : clear_flag
    task automatic pulse(input logic ext);
        @(posedge pclk);
        if (ext) external_trigger_pin <= 1; else timer_trigger_unit <= 1;
        repeat (4) @(posedge pclk);
        external_trigger_pin <= 0; timer_trigger_unit <= 0;
        repeat (2) @(posedge pclk);
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        apb(0, OFS_CTRL_STAT, 0); chk("ctrl_reset", 32'(CS_RESET), rd);
        apb(0, OFS_CONFIG, 0); chk("config_reset", 32'(CF_RESET), rd);
        apb(0, 8'h30, 0); chk("unmapped_err", 1, err);
        // a write while the clock enable is low must leave every register untouched
        clk_en <= 1'b0;
        apb(1, OFS_CTRL_STAT, 32'h00000040);
        clk_en <= 1'b1;
        apb(0, OFS_CTRL_STAT, 0); chk("frozen_write", 0, rd[CS_IRQ_EN]);
        $display("test reset done");
    endtask : t_reset
    task automatic t_group_single;
        k = n_strb;
        apb(1, OFS_CTRL_STAT, 32'h15A);
        // the register takes the write at the access edge; look one edge later
        @(posedge pclk);
        chk("clk_sel", 2'h1, conv_clock_select);
        wait_stop;
        chk("end_flag", 1, rd[CS_END_FLAG]);
        chk("irq", 1, conversion_end_irq);
        chk("strobes", 3, n_strb - k);
        chk("power_off", 0, analog_power);
        for (int i = 0; i < 3; i++) begin apb(0, OFS_RESULT_A + 8'(4 * i), 0); chk("result", {3'(i), 7'(k + i)}, rd); end
        clear_flag;
        apb(0, OFS_CTRL_STAT, 0); chk("flag_cleared", 0, rd[CS_END_FLAG]);
        $display("test group single done");
    endtask : t_group_single
    task automatic t_buffer;
        apb(1, OFS_CONFIG, 32'(BUF_ABCD));
        k = n_strb;
        apb(1, OFS_CTRL_STAT, 32'h15A);
        wait_irq;
        apb(1, OFS_CTRL_STAT, 32'h05A);
        apb(0, OFS_CTRL_STAT, 0); chk("no_read_no_clear", 1, rd[CS_END_FLAG]);
        xfer_service <= 1;
        // three shifts push the result A held before this test down into D
        for (int i = 0; i < 4; i++) begin apb(0, OFS_RESULT_A + 8'(4 * i), 0); chk("buf", i < 3 ? {3'h0, 7'(k + 2 - i)} : {3'h0, 7'(k - 3)}, rd); end
        xfer_service <= 0;
        apb(0, OFS_CTRL_STAT, 0); chk("xfer_clear", 0, rd[CS_END_FLAG]);
        apb(1, OFS_CONFIG, 32'(BUF_NONE));
        apb(0, OFS_STATUS, 0); chk("buf_count", 0, rd[5:4]);
        $display("test buffer done");
    endtask : t_buffer
    task automatic t_fast;
        time t0;
        apb(1, OFS_CONFIG, 32'h50);
        apb(1, OFS_CTRL_STAT, 32'h19);
        k = n_strb;
        pulse(0);
        wait_stop; chk("timer_strobes", 2, n_strb - k);
        chk("stays_powered", 1, analog_power);
        clear_flag;
        apb(1, OFS_CONFIG, 32'h70);
        k = n_strb; t0 = $time;
        pulse(1);
        wait_stop; chk("ext_strobes", 2, n_strb - k);
        chk("quick_restart", 1, ($time - t0) < 200 * 25);
        clear_flag;
        apb(1, OFS_CONFIG, 32'h30);
        repeat (3) @(posedge pclk); chk("power_cut", 0, analog_power);
        $display("test fast start done");
    endtask : t_fast
    task automatic t_scan;
        apb(1, OFS_CONFIG, 32'h08);
        apb(1, OFS_CTRL_STAT, 32'h15A);
        wait_irq; k = n_strb;
        repeat (60) @(posedge pclk); chk("paused", k, n_strb);
        apb(0, OFS_CTRL_STAT, 0); chk("scan_start_held", 1, rd[CS_START]);
        apb(1, OFS_CTRL_STAT, rd & ~32'h080);
        repeat (60) @(posedge pclk); chk("resumed", 1, n_strb != k);
        apb(1, OFS_CTRL_STAT, 32'h05A);
        $display("test group scan done");
    endtask : t_scan
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (30000) @(posedge pclk);
        n_fail++;
        $display("watchdog expired");
        report_and_stop;
    end
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        t_reset;
        t_group_single;
        t_buffer;
        t_fast;
        t_scan;
        report_and_stop;
    end
endmodule : testbench
